/* eeprom_fill_parallel_prog_tb_top.sv */
// Testbench joining programmer and device ends
`timescale 1ns/1ns
`define CHK(a, b) \
    begin \
        total_checks++; \
        if ((a) !== (b)) \
        begin \
            errors++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); \
        end \
    end
module eeprom_fill_parallel_prog_tb_top;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic       start = 1'b0;
    logic       block = 1'b0;
    logic [8:0] row_addr = 9'h000;
    logic [7:0] value = 8'h00;
    logic [8:0] rd_addr = 9'h000;
    logic [8:0] rd_addr2 = 9'h000;
    logic [7:0] rd_data;
    logic [7:0] rd_data2;
    logic       busy;
    logic       busy2;
    logic       done;
    logic       stb_q;
    logic [7:0] exp_mem [512];
    logic [7:0] log [$];
    logic [7:0] seq2 [15];
    int         errors = 0;
    int         total_checks = 0;
    int         seed = 7921;
    fill_link_if link ();
    fill_link_if link2 ();
    fill_device u_fill_device (.clk(clk), .srst(srst), .link(link),
        .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy));
    fill_programmer u_fill_programmer (.clk(clk), .srst(srst), .link(link),
        .start(start), .block(block), .row_addr(row_addr), .value(value),
        .done(done));
    fill_device u_fill_device2 (.clk(clk), .srst(srst), .link(link2),
        .rd_addr(rd_addr2), .rd_data(rd_data2), .busy(busy2));
    fill_link_sva #(.HALF(fill_pkg::STROBE_CYC), .ROW(fill_pkg::ROW_BYTES))
        u_fill_link_sva (.clk(clk), .srst(srst),
        .prog_byte_bus(link.prog_byte_bus),
        .strobe_clock_input(link.strobe_clock_input),
        .handshake_toggle(link.handshake_toggle),
        .result_port(link.result_port));
    initial
    begin
        forever #10 clk = ~clk;
    end
    // ----------------------------------------
    // Wire monitor: byte taken at each strobe rise
    // ----------------------------------------
    always @(posedge clk)
    begin
        stb_q <= link.strobe_clock_input;
        if (link.strobe_clock_input === 1'b1 && stb_q === 1'b0)
            log.push_back(link.prog_byte_bus);
    end
    function automatic logic [7:0] exp_byte(input int i, input logic blk,
        input logic [8:0] ra, input logic [7:0] v);
        logic [7:0] lau [6];
        lau = '{fill_pkg::LAUNCH_0, fill_pkg::LAUNCH_1, fill_pkg::LAUNCH_2,
                fill_pkg::LAUNCH_3, fill_pkg::LAUNCH_4, fill_pkg::LAUNCH_5};
        case (i)
            0, 3, 6: return fill_pkg::PREFIX_BYTE;
            1: return fill_pkg::SEL_CONFIG;
            2: return blk ? fill_pkg::CFG_BLOCK
                : (ra[8] ? fill_pkg::CFG_ROW_HI : fill_pkg::CFG_ROW_LO);
            4: return fill_pkg::SEL_DATA;
            5: return v;
            7: return fill_pkg::SEL_ADDR;
            8: return ra[7:0];
            default: return lau[(i - 9) % 6];
        endcase
    endfunction
    function automatic logic in_fill(input int a, input logic blk,
        input logic [8:0] ra);
        return blk || (a[8:6] == ra[8:6]);
    endfunction
    task automatic run_fill(input logic blk, input logic [8:0] ra,
        input logic [7:0] v);
        int n;
        logic busy_seen;
        busy_seen = 1'b0;
        log.delete();
        start <= 1'b1;
        block <= blk;
        row_addr <= ra;
        value <= v;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 20000)
        begin
            @(posedge clk);
            if (busy === 1'b1)
                busy_seen = 1'b1;
            n++;
        end
        `CHK(n < 20000, 1'b1)
        `CHK(busy_seen, 1'b1)
        `CHK(link.result_port[fill_pkg::DONE_BIT], 1'b1)
        `CHK(busy, 1'b0)
        `CHK(log.size() >= 15 && log.size() % 6 == 3, 1'b1)
        for (int i = 0; i < log.size(); i++)
            if (i != 8 || !blk)
                `CHK(log[i], exp_byte(i, blk, ra, v))
        for (int a = 0; a < 512; a++)
        begin
            if (in_fill(a, blk, ra))
                exp_mem[a] = v;
            rd_addr <= a[8:0];
            repeat (2) @(posedge clk);
            `CHK(rd_data, exp_mem[a])
        end
    endtask
    // ----------------------------------------
    // Hand driver on the second link
    // ----------------------------------------
    task automatic send2(input logic [7:0] b);
        logic t;
        t = link2.handshake_toggle;
        link2.prog_byte_bus <= b;
        repeat (fill_pkg::STROBE_CYC) @(posedge clk);
        link2.strobe_clock_input <= 1'b1;
        repeat (fill_pkg::STROBE_CYC) @(posedge clk);
        link2.strobe_clock_input <= 1'b0;
        repeat (fill_pkg::STROBE_CYC) @(posedge clk);
        `CHK(link2.handshake_toggle, ~t)
    endtask
    task automatic end_sim;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clk);
        errors++;
        $display("watchdog expired");
        end_sim();
    end
    initial
    begin
        link2.prog_byte_bus <= 8'h00;
        link2.strobe_clock_input <= 1'b0;
        seq2 = '{8'h75, 8'h99, 8'h75, 8'hF1, 8'h21, 8'h75, 8'hF2, 8'h5A,
                 8'h75, 8'hF3, 8'h80, 8'hE5, 8'hF1, 8'hF5, 8'hA1};
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        run_fill(1'b1, 9'($random(seed)), 8'($random(seed)));
        run_fill(1'b0, 9'h1FF, 8'hA5);
        run_fill(1'b0, 9'h000, 8'hFF);
        for (int k = 0; k < 4; k++)
            run_fill(1'($random(seed)), 9'($random(seed)),
                     8'($random(seed)));
        // Bad selector and wrong launch byte, then a good launch
        foreach (seq2[i])
            send2(seq2[i]);
        `CHK(busy2, 1'b0)
        `CHK(link2.result_port[7], 1'b0)
        for (int i = 9; i < 15; i++)
            send2(exp_byte(i, 1'b0, 9'h000, 8'h00));
        `CHK(link2.result_port[7], 1'b1)
        rd_addr2 <= 9'h180;
        repeat (2) @(posedge clk);
        `CHK(rd_data2, 8'h5A)
        rd_addr2 <= 9'h1BF;
        repeat (2) @(posedge clk);
        `CHK(rd_data2, 8'h5A)
        end_sim();
    end
endmodule

/* fill_device.sv */
// Device end: byte sequencer and EEPROM fill engine
`timescale 1ns/1ns
module fill_device #(
    parameter int DEPTH = fill_pkg::ARRAY_BYTES,
    parameter int ROW   = fill_pkg::ROW_BYTES
) (
    input  wire logic   clk,      // System clock
    input  wire logic   srst,     // Synchronous reset
    fill_link_if.device link,     // Programming link
    input  wire logic   [8:0] rd_addr, // Array peek address
    output logic        [7:0] rd_data, // Array peek data
    output logic        busy      // Fill in progress
);
    typedef enum {ST_IDLE, ST_SEL, ST_ARG, ST_LAUNCH} seq_type;
    typedef enum {ARG_CFG, ARG_DATA, ARG_ADDR} arg_type;

    logic [7:0] mem [DEPTH];
    logic [2:0] strb_sync_q;
    logic [7:0] bus_s1_q;
    logic [7:0] bus_s2_q;
    logic       strb_rise;
    seq_type    seq_q;
    arg_type    arg_q;
    logic [2:0] lcnt_q;
    logic       a8_q;
    logic       block_q;
    logic [7:0] fill_val_q;
    logic [7:0] row_lo_q;
    logic       run_q;
    logic       done_q;
    logic [8:0] waddr_q;
    logic [8:0] wleft_q;
    logic       hs_q;
    logic [7:0] launch_byte;
    logic       launched;
    logic [8:0] row_base;

    // ---------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            strb_sync_q <= 3'h0;
            bus_s1_q    <= 8'h00;
            bus_s2_q    <= 8'h00;
        end
        else
        begin
            strb_sync_q <= {strb_sync_q[1:0], link.strobe_clock_input};
            bus_s1_q    <= link.prog_byte_bus;
            bus_s2_q    <= bus_s1_q;
        end
    end
    assign strb_rise = strb_sync_q[1] & ~strb_sync_q[2];

    always_comb
    begin
        unique case (lcnt_q)
            3'h0: launch_byte = fill_pkg::LAUNCH_0;
            3'h1: launch_byte = fill_pkg::LAUNCH_1;
            3'h2: launch_byte = fill_pkg::LAUNCH_2;
            3'h3: launch_byte = fill_pkg::LAUNCH_3;
            3'h4: launch_byte = fill_pkg::LAUNCH_4;
            default: launch_byte = fill_pkg::LAUNCH_5;
        endcase
    end

    assign launched = strb_rise && seq_q == ST_LAUNCH
                      && bus_s2_q == launch_byte
                      && lcnt_q == 3'(fill_pkg::LAUNCH_LEN - 1);
    assign row_base = {a8_q, row_lo_q & 8'hC0};

    // ---------------------------------------------
    // Byte sequencer
    // ---------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            seq_q      <= ST_IDLE;
            arg_q      <= ARG_CFG;
            lcnt_q     <= 3'h0;
            a8_q       <= 1'b0;
            block_q    <= 1'b0;
            fill_val_q <= 8'h00;
            row_lo_q   <= 8'h00;
            hs_q       <= 1'b0;
        end
        else if (strb_rise)
        begin
            hs_q <= ~hs_q;
            unique case (seq_q)
                ST_IDLE:
                begin
                    if (bus_s2_q == fill_pkg::PREFIX_BYTE)
                        seq_q <= ST_SEL;
                    else if (bus_s2_q == fill_pkg::LAUNCH_0)
                    begin
                        seq_q  <= ST_LAUNCH;
                        lcnt_q <= 3'h1;
                    end
                end
                ST_SEL:
                begin
                    seq_q <= ST_ARG;
                    if (bus_s2_q == fill_pkg::SEL_CONFIG)
                        arg_q <= ARG_CFG;
                    else if (bus_s2_q == fill_pkg::SEL_DATA)
                        arg_q <= ARG_DATA;
                    else if (bus_s2_q == fill_pkg::SEL_ADDR)
                        arg_q <= ARG_ADDR;
                    else
                        seq_q <= ST_IDLE;
                end
                ST_ARG:
                begin
                    seq_q <= ST_IDLE;
                    unique case (arg_q)
                        ARG_CFG:
                        begin
                            a8_q    <= bus_s2_q[fill_pkg::CFG_A8_BIT];
                            block_q <=
                                bus_s2_q[fill_pkg::CFG_BLOCK_BIT];
                        end
                        ARG_DATA: fill_val_q <= bus_s2_q;
                        ARG_ADDR: row_lo_q   <= bus_s2_q;
                    endcase
                end
                ST_LAUNCH:
                begin
                    if (bus_s2_q != launch_byte || launched)
                    begin
                        seq_q  <= ST_IDLE;
                        lcnt_q <= 3'h0;
                    end
                    else
                        lcnt_q <= lcnt_q + 3'h1;
                end
            endcase
        end
    end

    // ---------------------------------------------
    // Fill engine, one byte per clock
    // ---------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            run_q   <= 1'b0;
            done_q  <= 1'b0;
            waddr_q <= 9'h000;
            wleft_q <= 9'h000;
        end
        else if (run_q)
        begin
            waddr_q <= waddr_q + 9'h001;
            wleft_q <= wleft_q - 9'h001;
            if (wleft_q == 9'h000)
            begin
                run_q  <= 1'b0;
                done_q <= 1'b1;
            end
        end
        else if (launched && !done_q)
        begin
            run_q   <= 1'b1;
            waddr_q <= block_q ? 9'h000 : row_base;
            wleft_q <= block_q ? 9'(DEPTH - 1) : 9'(ROW - 1);
        end
        // Bare relaunch after completion keeps the flag set
        else if (strb_rise && seq_q == ST_IDLE
                 && bus_s2_q != fill_pkg::LAUNCH_0)
            done_q <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (run_q)
            mem[waddr_q] <= fill_val_q;
    end

    // ---------------------------------------------
    // Outputs
    // ---------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            link.result_port <= 8'h00;
            rd_data          <= 8'h00;
            busy             <= 1'b0;
            link.handshake_toggle <= 1'b0;
        end
        else
        begin
            link.result_port <= {done_q, 7'h00};
            rd_data          <= mem[rd_addr];
            busy             <= run_q;
            link.handshake_toggle <= hs_q;
        end
    end
endmodule

/* fill_link_if.sv */
// Parallel programming link between programmer and device
`timescale 1ns/1ns
interface fill_link_if;
    logic [7:0] prog_byte_bus;      // Programmer to device byte
    logic       strobe_clock_input; // Programmer strobe
    logic       handshake_toggle;   // Device acceptance toggle
    logic [7:0] result_port;        // Device result byte
    modport device (
        input  prog_byte_bus,
        input  strobe_clock_input,
        output handshake_toggle,
        output result_port
    );
    modport programmer (
        output prog_byte_bus,
        output strobe_clock_input,
        input  handshake_toggle,
        input  result_port
    );
endinterface

/* fill_link_sva.sv */
// Concurrent checks on the fill programming link
`timescale 1ns/1ns
module fill_link_sva #(
    parameter int HALF = 50,
    parameter int ROW  = 64
) (
    input wire logic       clk,                // System clock
    input wire logic       srst,               // Sync reset
    input wire logic [7:0] prog_byte_bus,      // Byte bus
    input wire logic       strobe_clock_input, // Strobe
    input wire logic       handshake_toggle,   // Acceptance toggle
    input wire logic [7:0] result_port         // Result byte
);
    logic [9:0] run_q;
    logic [9:0] rise_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ----------------------------------------
    // Strobe level run and time since launch end
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst || $changed(strobe_clock_input))
            run_q <= 10'h000;
        else if (run_q != 10'h3FF)
            run_q <= run_q + 10'h001;
    end
    always_ff @(posedge clk)
    begin
        if (srst || ($rose(strobe_clock_input) && prog_byte_bus == 8'h00))
            rise_q <= 10'h000;
        else if (rise_q != 10'h3FF)
            rise_q <= rise_q + 10'h001;
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_toggle_answer: assert property ($rose(strobe_clock_input) |=>
        ##[0:5] $changed(handshake_toggle)) else $error("no toggle");
    a_toggle_in_high: assert property ($changed(handshake_toggle)
        |-> strobe_clock_input) else $error("toggle without strobe");
    a_bus_stable: assert property (strobe_clock_input
        |-> $stable(prog_byte_bus)) else $error("bus moved in strobe");
    a_strobe_width: assert property ($changed(strobe_clock_input)
        |-> run_q >= 10'(HALF - 1)) else $error("strobe phase short");
    a_result_spare: assert property (result_port[6:0] == 7'h00)
        else $error("spare result bits set");
    a_done_clear: assert property ($fell(result_port[7])
        |-> strobe_clock_input && prog_byte_bus != fill_pkg::LAUNCH_0)
        else $error("done cleared without setup byte");
    a_fill_time: assert property ($rose(result_port[7])
        |-> rise_q >= 10'(ROW)) else $error("done too early");
    a_reset_idle: assert property ($fell(srst) |-> !strobe_clock_input
        && !handshake_toggle && result_port == 8'h00)
        else $error("link not idle after reset");
    c_done: cover property ($rose(result_port[7]));
    c_toggle: cover property ($changed(handshake_toggle));
    c_clear: cover property ($fell(result_port[7]));
endmodule

/* fill_pkg.sv */
// Shared constants for the EEPROM fill programming link
package fill_pkg;
    localparam logic [7:0] PREFIX_BYTE   = 8'h75;
    localparam logic [7:0] SEL_CONFIG    = 8'hF1;
    localparam logic [7:0] SEL_DATA      = 8'hF2;
    localparam logic [7:0] SEL_ADDR      = 8'hF3;
    localparam logic [7:0] CFG_BLOCK     = 8'h31;
    localparam logic [7:0] CFG_ROW_LO    = 8'h20;
    localparam logic [7:0] CFG_ROW_HI    = 8'h21;
    localparam logic [7:0] LAUNCH_0      = 8'hE5;
    localparam logic [7:0] LAUNCH_1      = 8'hF1;
    localparam logic [7:0] LAUNCH_2      = 8'hF5;
    localparam logic [7:0] LAUNCH_3      = 8'hA0;
    localparam logic [7:0] LAUNCH_4      = 8'h00;
    localparam logic [7:0] LAUNCH_5      = 8'h00;
    localparam int         LAUNCH_LEN    = 6;
    localparam int         CFG_A8_BIT    = 0;
    localparam int         CFG_BLOCK_BIT = 4;
    localparam int         DONE_BIT      = 7;
    localparam int         ARRAY_BYTES   = 512;
    localparam int         ROW_BYTES     = 64;
    localparam int         CLK_MHZ       = 50;
    localparam int         STROBE_MIN_NS = 1000;
    localparam int         STROBE_CYC    =
        (STROBE_MIN_NS * CLK_MHZ + 999) / 1000;
endpackage

/* fill_programmer.sv */
// Programmer end: drives the fill byte sequence and polls done
`timescale 1ns/1ns
module fill_programmer #(
    parameter int HALF = fill_pkg::STROBE_CYC
) (
    input  wire logic       clk,       // System clock
    input  wire logic       srst,      // Synchronous reset
    fill_link_if.programmer link,      // Programming link
    input  wire logic       start,     // Start fill, one pulse
    input  wire logic       block,     // 1 block fill, 0 row fill
    input  wire logic [8:0] row_addr,  // Row address for row fill
    input  wire logic [7:0] value,     // Fill value
    output logic            done       // Fill completed, pulse
);
    typedef enum {P_IDLE, P_HIGH, P_LOW, P_CHECK, P_POLL} pst_type;

    pst_type    st_q;
    logic [3:0] idx_q;
    logic [7:0] cnt_q;
    logic [1:0] hs_sync_q;
    logic       hs_ref_q;
    logic [1:0] done_sync_q;
    logic       blk_q;
    logic [8:0] ra_q;
    logic [7:0] val_q;
    logic [7:0] cur_byte;

    // Bytes 0..8 set up, 9..14 launch
    always_comb
    begin
        unique case (idx_q)
            4'h0, 4'h3, 4'h6: cur_byte = fill_pkg::PREFIX_BYTE;
            4'h1: cur_byte = fill_pkg::SEL_CONFIG;
            4'h2: cur_byte = blk_q ? fill_pkg::CFG_BLOCK
                           : (ra_q[8] ? fill_pkg::CFG_ROW_HI
                                      : fill_pkg::CFG_ROW_LO);
            4'h4: cur_byte = fill_pkg::SEL_DATA;
            4'h5: cur_byte = val_q;
            4'h7: cur_byte = fill_pkg::SEL_ADDR;
            4'h8: cur_byte = ra_q[7:0];
            4'h9: cur_byte = fill_pkg::LAUNCH_0;
            4'hA: cur_byte = fill_pkg::LAUNCH_1;
            4'hB: cur_byte = fill_pkg::LAUNCH_2;
            4'hC: cur_byte = fill_pkg::LAUNCH_3;
            4'hD: cur_byte = fill_pkg::LAUNCH_4;
            default: cur_byte = fill_pkg::LAUNCH_5;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            hs_sync_q   <= 2'h0;
            done_sync_q <= 2'h0;
        end
        else
        begin
            hs_sync_q   <= {hs_sync_q[0], link.handshake_toggle};
            done_sync_q <= {done_sync_q[0],
                            link.result_port[fill_pkg::DONE_BIT]};
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_q     <= P_IDLE;
            idx_q    <= 4'h0;
            cnt_q    <= 8'h00;
            hs_ref_q <= 1'b0;
            blk_q    <= 1'b0;
            ra_q     <= 9'h000;
            val_q    <= 8'h00;
            done     <= 1'b0;
            link.prog_byte_bus      <= 8'h00;
            link.strobe_clock_input <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            unique case (st_q)
                P_IDLE:
                begin
                    if (start)
                    begin
                        blk_q    <= block;
                        ra_q     <= block ? 9'h100 : row_addr;
                        val_q    <= value;
                        idx_q    <= 4'h0;
                        hs_ref_q <= hs_sync_q[1];
                        cnt_q    <= 8'h00;
                        st_q     <= P_LOW;
                    end
                end
                P_LOW:
                begin
                    link.prog_byte_bus <= cur_byte;
                    link.strobe_clock_input <= 1'b0;
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == 8'(HALF - 1))
                    begin
                        cnt_q <= 8'h00;
                        link.strobe_clock_input <= 1'b1;
                        st_q  <= P_HIGH;
                    end
                end
                P_HIGH:
                begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == 8'(HALF - 1))
                    begin
                        cnt_q <= 8'h00;
                        link.strobe_clock_input <= 1'b0;
                        st_q  <= P_CHECK;
                    end
                end
                P_CHECK:
                begin
                    // Low phase counts as wait for the sync delay
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == 8'(HALF - 1))
                    begin
                        cnt_q <= 8'h00;
                        if (hs_sync_q[1] != hs_ref_q)
                        begin
                            hs_ref_q <= hs_sync_q[1];
                            if (idx_q == 4'hE)
                                st_q <= P_POLL;
                            else
                            begin
                                idx_q <= idx_q + 4'h1;
                                st_q  <= P_LOW;
                            end
                        end
                        else
                        begin
                            link.strobe_clock_input <= 1'b1;
                            st_q <= P_HIGH;
                        end
                    end
                end
                P_POLL:
                begin
                    if (done_sync_q[1])
                    begin
                        done <= 1'b1;
                        st_q <= P_IDLE;
                    end
                    else
                    begin
                        idx_q <= 4'h9;
                        st_q  <= P_LOW;
                    end
                end
            endcase
        end
    end
endmodule
